// ---- pfrs_assertions.sv ----
// port checks for the fault sequencer
`timescale 1ns/100ps
module pfrs_assertions import pfrs_pkg::*; #(
    parameter int FB_LOSS_CYCLES   = 64,
    parameter int UV_CYCLES        = 16384,
    parameter int OVL_TRIP_CYCLES  = 16384,
    parameter int RESTART_ATTEMPTS = 8,
    parameter int START_PULSE_CYC  = 70
) (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        clk_en_in,
    input wire logic        half_cycle_in,
    input wire logic        restart_tick_in,
    input wire logic        feedback_loss_in,
    input wire logic        comp_at_ceiling_in,
    input wire logic        overload_in,
    input wire logic        drive_output_a_out,
    input wire logic        drive_output_b_out,
    input wire logic        clamp_out,
    input wire logic        shutdown_out,
    input wire pfrs_fault_e fault_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_clamp_drives: assert property (clamp_out |-> !drive_output_a_out && !drive_output_b_out)
        else $error("drive active while clamped");
    chk_shut_clamp: assert property (shutdown_out |-> clamp_out)
        else $error("shutdown without clamp");
    chk_hold_shut: assert property ($rose(shutdown_out) |-> shutdown_out [*8])
        else $error("shutdown left too early");
    chk_pulse_order: assert property ($fell(shutdown_out) |->
        drive_output_a_out [*4] ##1 drive_output_b_out [*4])
        else $error("start pulses wrong");
    chk_run_clear: assert property ($fell(shutdown_out) |-> ##[8:10] fault_out == PFRS_FAULT_NONE)
        else $error("fault not cleared after restart");
    chk_fault_held: assert property (shutdown_out |-> fault_out != PFRS_FAULT_NONE)
        else $error("shutdown without fault code");
    chk_fb_cause: assert property ($rose(shutdown_out) && fault_out == PFRS_FAULT_FB |->
        $past(feedback_loss_in, 3))
        else $error("feedback trip without loss");
    chk_uv_cause: assert property ($rose(shutdown_out) && fault_out == PFRS_FAULT_UV |->
        $past(comp_at_ceiling_in, 3))
        else $error("undervoltage trip without ceiling");
    chk_ovl_cause: assert property ($rose(shutdown_out) && fault_out == PFRS_FAULT_OVL |->
        $past(overload_in, 3))
        else $error("overload trip without overload");
endmodule : pfrs_assertions
bind pfrs_sequencer pfrs_assertions #(.FB_LOSS_CYCLES(FB_LOSS_CYCLES), .UV_CYCLES(UV_CYCLES),
    .OVL_TRIP_CYCLES(OVL_TRIP_CYCLES), .RESTART_ATTEMPTS(RESTART_ATTEMPTS),
    .START_PULSE_CYC(START_PULSE_CYC)) chk (.*);

// ---- pfrs_cfg.svh ----
// constants for the fault supervision and restart sequencer
`ifndef PFRS_CFG_SVH
`define PFRS_CFG_SVH
`define PFRS_FB_LOSS_CYCLES   64
`define PFRS_UV_CYCLES        16384
`define PFRS_OVL_TRIP_CYCLES  16384
`define PFRS_RESTART_ATTEMPTS 8
`define PFRS_CLK_MHZ          100
`define PFRS_START_PULSE_NS   700
`define PFRS_START_PULSE_CYC  ((`PFRS_START_PULSE_NS * `PFRS_CLK_MHZ) / 1000)
`endif

// ---- pfrs_partner.sv ----
// converter and comparator model: cycles stop while clamped
`timescale 1ns/100ps
module pfrs_partner (
    input  wire logic       clk_in,
    input  wire logic       clamp_in,
    input  wire logic [2:0] fault_set_in,
    output logic            half_cycle_out = 1'b0,
    output logic            restart_tick_out = 1'b0,
    output logic            feedback_loss_out,
    output logic            comp_at_ceiling_out,
    output logic            overload_out
);
    logic [1:0] div_r = 2'h0;
    always @(posedge clk_in)
    begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3)
        begin
            half_cycle_out   <= !clamp_in && !half_cycle_out;
            restart_tick_out <= clamp_in && !restart_tick_out;
        end
    end
    assign {overload_out, comp_at_ceiling_out, feedback_loss_out} = fault_set_in;
endmodule : pfrs_partner

// ---- pfrs_pkg.sv ----
// types for the fault supervision and restart sequencer
package pfrs_pkg;
    typedef enum logic [1:0]
    {
        PFRS_RUN      = 2'b00,
        PFRS_SHUTDOWN = 2'b01,
        PFRS_PULSE    = 2'b10
    } pfrs_state_e;

    typedef enum logic [1:0]
    {
        PFRS_FAULT_NONE = 2'b00,
        PFRS_FAULT_FB   = 2'b01,
        PFRS_FAULT_UV   = 2'b10,
        PFRS_FAULT_OVL  = 2'b11
    } pfrs_fault_e;
endpackage : pfrs_pkg

// ---- pfrs_sequencer.sv ----
// fault supervision and auto-restart sequencer
`timescale 1ns/100ps
`include "pfrs_cfg.svh"
module pfrs_sequencer #(
    parameter int FB_LOSS_CYCLES   = `PFRS_FB_LOSS_CYCLES,
    parameter int UV_CYCLES        = `PFRS_UV_CYCLES,
    parameter int OVL_TRIP_CYCLES  = `PFRS_OVL_TRIP_CYCLES,
    parameter int RESTART_ATTEMPTS = `PFRS_RESTART_ATTEMPTS,
    parameter int START_PULSE_CYC  = `PFRS_START_PULSE_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 half_cycle_in,
    input  wire logic                 restart_tick_in,
    input  wire logic                 feedback_loss_in,
    input  wire logic                 comp_at_ceiling_in,
    input  wire logic                 overload_in,
    output logic                      drive_output_a_out,
    output logic                      drive_output_b_out,
    output logic                      clamp_out,
    output logic                      shutdown_out,
    output pfrs_pkg::pfrs_fault_e     fault_out
);
    import pfrs_pkg::*;

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    logic [4:0] in_s1_r;
    logic [4:0] in_s2_r;
    logic [4:0] pins;
    assign pins = {half_cycle_in, restart_tick_in, feedback_loss_in,
                   comp_at_ceiling_in, overload_in};
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_s1_r <= 5'h00;
            in_s2_r <= 5'h00;
        end
        else
        begin
            in_s1_r <= pins;
            in_s2_r <= in_s1_r;
        end
    end

    logic half_d_r;
    logic tick_d_r;
    logic cyc;
    logic tick;
    logic fb_low;
    logic at_ceil;
    logic ovl;
    assign cyc     = in_s2_r[4] & ~half_d_r;
    assign tick    = in_s2_r[3] & ~tick_d_r;
    assign fb_low  = in_s2_r[2];
    assign at_ceil = in_s2_r[1];
    assign ovl     = in_s2_r[0];

    // ------------------------------------------------------------
    // fault counters and restart sequencer
    // ------------------------------------------------------------
    localparam int FW = $clog2(FB_LOSS_CYCLES + 1);
    localparam int UW = $clog2(UV_CYCLES + 1);
    localparam int OW = $clog2(OVL_TRIP_CYCLES + 1);
    localparam int AW = $clog2(RESTART_ATTEMPTS + 1);
    localparam int PW = $clog2(START_PULSE_CYC + 1);

    pfrs_state_e     state_r, state_nxt;
    pfrs_fault_e     fault_r, fault_nxt;
    logic [FW-1:0]   fb_cnt_r, fb_cnt_nxt;
    logic [UW-1:0]   uv_cnt_r, uv_cnt_nxt;
    logic [OW-1:0]   ovl_cnt_r, ovl_cnt_nxt;
    logic [AW-1:0]   att_cnt_r, att_cnt_nxt;
    logic [PW-1:0]   pls_cnt_r, pls_cnt_nxt;
    logic            pls_b_r, pls_b_nxt;
    logic            phase_r, phase_nxt;

    always_comb
    begin
        state_nxt   = state_r;
        fault_nxt   = fault_r;
        fb_cnt_nxt  = fb_cnt_r;
        uv_cnt_nxt  = uv_cnt_r;
        ovl_cnt_nxt = ovl_cnt_r;
        att_cnt_nxt = att_cnt_r;
        pls_cnt_nxt = pls_cnt_r;
        pls_b_nxt   = pls_b_r;
        phase_nxt   = phase_r;
        unique case (state_r)
            PFRS_RUN:
            begin
                if (cyc)
                begin
                    phase_nxt = ~phase_r;
                    if (fb_low)
                        fb_cnt_nxt = fb_cnt_r + FW'(1);
                    else
                        fb_cnt_nxt = '0;
                    if (at_ceil)
                        uv_cnt_nxt = uv_cnt_r + UW'(1);
                    else
                        uv_cnt_nxt = '0;
                    if (ovl)
                        ovl_cnt_nxt = ovl_cnt_r + OW'(1);
                    else if (ovl_cnt_r != '0)
                        ovl_cnt_nxt = ovl_cnt_r - OW'(1);
                    if (fb_low && fb_cnt_r == FW'(FB_LOSS_CYCLES - 1))
                        fault_nxt = PFRS_FAULT_FB;
                    else if (at_ceil && uv_cnt_r == UW'(UV_CYCLES - 1))
                        fault_nxt = PFRS_FAULT_UV;
                    else if (ovl && ovl_cnt_r == OW'(OVL_TRIP_CYCLES - 1))
                        fault_nxt = PFRS_FAULT_OVL;
                    if (fault_nxt != PFRS_FAULT_NONE)
                    begin
                        state_nxt   = PFRS_SHUTDOWN;
                        fb_cnt_nxt  = '0;
                        uv_cnt_nxt  = '0;
                        ovl_cnt_nxt = '0;
                        att_cnt_nxt = '0;
                    end
                end
            end
            PFRS_SHUTDOWN:
            begin
                if (tick)
                begin
                    att_cnt_nxt = att_cnt_r + AW'(1);
                    if (att_cnt_r == AW'(RESTART_ATTEMPTS - 1))
                    begin
                        state_nxt   = PFRS_PULSE;
                        pls_cnt_nxt = '0;
                        pls_b_nxt   = 1'b0;
                    end
                end
            end
            PFRS_PULSE:
            begin
                pls_cnt_nxt = pls_cnt_r + PW'(1);
                if (pls_cnt_r == PW'(START_PULSE_CYC - 1))
                begin
                    pls_cnt_nxt = '0;
                    if (pls_b_r)
                    begin
                        state_nxt = PFRS_RUN;
                        fault_nxt = PFRS_FAULT_NONE;
                        phase_nxt = 1'b0;
                    end
                    else
                        pls_b_nxt = 1'b1;
                end
            end
            default:
                state_nxt = PFRS_SHUTDOWN;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_d_r  <= 1'b0;
            tick_d_r  <= 1'b0;
            state_r   <= PFRS_RUN;
            fault_r   <= PFRS_FAULT_NONE;
            fb_cnt_r  <= '0;
            uv_cnt_r  <= '0;
            ovl_cnt_r <= '0;
            att_cnt_r <= '0;
            pls_cnt_r <= '0;
            pls_b_r   <= 1'b0;
            phase_r   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            half_d_r  <= in_s2_r[4];
            tick_d_r  <= in_s2_r[3];
            state_r   <= state_nxt;
            fault_r   <= fault_nxt;
            fb_cnt_r  <= fb_cnt_nxt;
            uv_cnt_r  <= uv_cnt_nxt;
            ovl_cnt_r <= ovl_cnt_nxt;
            att_cnt_r <= att_cnt_nxt;
            pls_cnt_r <= pls_cnt_nxt;
            pls_b_r   <= pls_b_nxt;
            phase_r   <= phase_nxt;
        end
    end

    // ------------------------------------------------------------
    // drive outputs, registered
    // ------------------------------------------------------------
    logic drv_a_r;
    logic drv_b_r;
    logic clamp_r;
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_a_r <= 1'b0;
            drv_b_r <= 1'b0;
            clamp_r <= 1'b0;
        end
        else if (clk_en_in)
        begin
            clamp_r <= (state_nxt == PFRS_SHUTDOWN);
            drv_a_r <= (state_nxt == PFRS_RUN) ? ~phase_nxt
                     : (state_nxt == PFRS_PULSE) & ~pls_b_nxt;
            drv_b_r <= (state_nxt == PFRS_RUN) ? phase_nxt
                     : (state_nxt == PFRS_PULSE) & pls_b_nxt;
        end
    end

    assign drive_output_a_out = drv_a_r;
    assign drive_output_b_out = drv_b_r;
    assign clamp_out          = clamp_r;
    assign shutdown_out       = (state_r == PFRS_SHUTDOWN);
    assign fault_out          = fault_r;
endmodule : pfrs_sequencer

// ---- pfrs_sequencer_test.sv ----
// self-checking bench for the fault sequencer
`timescale 1ns/100ps
module pfrs_sequencer_test;
    import pfrs_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  fset = 3'h0;
    logic        hc, rt, fb, uv, ov, da, db, clamp, shut;
    pfrs_fault_e fault;
    int          error_cnt = 0;
    int          samples_checked = 0;
    always #5 clk = ~clk;
    pfrs_partner far (.clk_in(clk), .clamp_in(clamp), .fault_set_in(fset),
        .half_cycle_out(hc), .restart_tick_out(rt), .feedback_loss_out(fb),
        .comp_at_ceiling_out(uv), .overload_out(ov));
    pfrs_sequencer #(.UV_CYCLES(20), .OVL_TRIP_CYCLES(20), .RESTART_ATTEMPTS(3),
        .START_PULSE_CYC(4)) uut (.clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
        .half_cycle_in(hc), .restart_tick_in(rt), .feedback_loss_in(fb),
        .comp_at_ceiling_in(uv), .overload_in(ov), .drive_output_a_out(da),
        .drive_output_b_out(db), .clamp_out(clamp), .shutdown_out(shut), .fault_out(fault));
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // counts converter cycles until shutdown or the limit
    task automatic run_until_shut(input int lim, output int n);
        logic prev;
        n = 0;
        prev = hc;
        while (!shut && n <= lim)
        begin
            @(posedge clk);
            #1;
            if (hc && !prev)
                n++;
            prev = hc;
        end
    endtask : run_until_shut
    task automatic recover(input pfrs_fault_e f, input logic keep);
        int   k;
        int   ticks;
        logic rprev;
        ticks = 0;
        rprev = rt;
        check("fault", f, fault);
        check("clamp", 1, clamp);
        check("drives", 0, {da, db});
        if (!keep) @(posedge clk) fset <= 3'h0;
        for (k = 0; k < 400 && shut; k++)
        begin
            @(posedge clk);
            #1;
            if (rt && !rprev)
                ticks++;
            rprev = rt;
        end
        check("attempts", 3, ticks);
        if (shut)
        begin
            check("restart", 0, 1);
            stop_test();
        end
        check("pulse a", 2, {da, db});
        repeat (4) @(posedge clk);
        #1 check("pulse b", 1, {da, db});
        repeat (5) @(posedge clk);
        #1 check("fault", 0, fault);
    endtask : recover
    task automatic fb_test;
        int n;
        @(posedge clk) fset <= 3'h1;
        run_until_shut(40, n);
        check("early fb trip", 0, shut);
        @(posedge clk) fset <= 3'h0;
        repeat (24) @(posedge clk);
        fset <= 3'h1;
        run_until_shut(80, n);
        check("fb trip window", 1, n >= 63 && n <= 65);
        recover(PFRS_FAULT_FB, 1'b0);
        run_until_shut(70, n);
        check("fb cleared run", 0, shut);
    endtask : fb_test
    task automatic uv_test;
        int n;
        @(posedge clk) fset <= 3'h2;
        run_until_shut(30, n);
        check("uv trip window", 1, n >= 19 && n <= 21);
        recover(PFRS_FAULT_UV, 1'b1);
        run_until_shut(30, n);
        check("uv retrip", 1, shut);
        recover(PFRS_FAULT_UV, 1'b0);
    endtask : uv_test
    task automatic ovl_test;
        int n;
        @(posedge clk) fset <= 3'h4;
        run_until_shut(9, n);
        @(posedge clk) fset <= 3'h0;
        run_until_shut(5, n);
        @(posedge clk) fset <= 3'h4;
        run_until_shut(30, n);
        check("ovl net trip", 1, n >= 13 && n <= 19);
        recover(PFRS_FAULT_OVL, 1'b0);
    endtask : ovl_test
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check("idle fault", 0, fault);
        check("idle shut", 0, shut);
        fb_test();
        uv_test();
        ovl_test();
        stop_test();
    end
endmodule : pfrs_sequencer_test
